/* File: rec_ch4_cfg.sv */
`timescale 1ns/1ps
module rec_ch4_cfg
  import rec_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regHit,
  input wire logic sampleTick,
  output logic ch4CloneFromCh2,
  output logic ch4Mute,
  output logic [7:0] ch4VolumeCode,
  output logic signed [9:0] ch4VolumeHalfDb,
  output logic [3:0] ch4FineGain,
  output logic signed [4:0] ch4FineTenthDb,
  output logic [5:0] ch4PhaseDelay,
  output logic [3:0] inputCmTrim,
  output logic cmTrimOneHot,
  output logic quantizerOffsetCal,
  output logic invertRecData,
  output logic [2:0] out1SourceSelect,
  output logic [2:0] out1Routing,
  output logic out1RoutingIgnored,
  output out_route_t out1Route
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] merge_write(input logic [7:0] wdata, input logic [7:0] mask,
      input logic [7:0] rstVal);
    merge_write = (wdata & mask) | (rstVal & ~mask);
  endfunction : merge_write

  // volume code to half-dB steps relative to unity: 1 -> -160, 255 -> +94
  function automatic logic signed [9:0] vol_to_half_db(input logic [7:0] code);
    vol_to_half_db = $signed({2'b00, code}) - $signed({2'b00, VOL_UNITY});
  endfunction : vol_to_half_db

  // ==========================================================
  // register storage
  logic [7:0] inputReg, inputNext;
  logic [7:0] volumeReg, volumeNext;
  logic [7:0] fineReg, fineNext;
  logic [7:0] phaseReg, phaseNext;
  logic [7:0] commonReg, commonNext;
  logic [7:0] sourceReg, sourceNext;
  logic [7:0] rdataReg, rdataNext;
  logic hitReg, hitNext;

  wire selInput = (regAddr == OFS_CH4_INPUT);
  wire selVolume = (regAddr == OFS_CH4_VOLUME);
  wire selFine = (regAddr == OFS_CH4_FINE);
  wire selPhase = (regAddr == OFS_CH4_PHASE);
  wire selCommon = (regAddr == OFS_REC_COMMON);
  wire selSource = (regAddr == OFS_OUT1_SOURCE);
  wire anySel = selInput | selVolume | selFine | selPhase | selCommon | selSource;

  // reserved bits are never stored from the bus, so they always read as reset
  assign inputNext = (regWrite && selInput) ?
      merge_write(regWdata, MASK_CH4_INPUT, RST_CH4_INPUT) : inputReg;
  assign volumeNext = (regWrite && selVolume) ?
      merge_write(regWdata, MASK_CH4_VOLUME, RST_CH4_VOLUME) : volumeReg;
  assign fineNext = (regWrite && selFine) ?
      merge_write(regWdata, MASK_CH4_FINE, RST_CH4_FINE) : fineReg;
  assign phaseNext = (regWrite && selPhase) ?
      merge_write(regWdata, MASK_CH4_PHASE, RST_CH4_PHASE) : phaseReg;
  assign commonNext = (regWrite && selCommon) ?
      merge_write(regWdata, MASK_REC_COMMON, RST_REC_COMMON) : commonReg;
  // source codes 6/7 are stored as written; the decoder keeps the driver off
  assign sourceNext = (regWrite && selSource) ?
      merge_write(regWdata, MASK_OUT1_SOURCE, RST_OUT1_SOURCE) : sourceReg;

  wire [7:0] readMux = selInput ? inputReg :
      selVolume ? volumeReg :
      selFine ? fineReg :
      selPhase ? phaseReg :
      selCommon ? commonReg :
      selSource ? sourceReg : 8'h00;
  assign rdataNext = regRead ? readMux : rdataReg;
  assign hitNext = (regRead || regWrite) && anySel;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      inputReg <= RST_CH4_INPUT;
      volumeReg <= RST_CH4_VOLUME;
      fineReg <= RST_CH4_FINE;
      phaseReg <= RST_CH4_PHASE;
      commonReg <= RST_REC_COMMON;
      sourceReg <= RST_OUT1_SOURCE;
      rdataReg <= 8'h00;
      hitReg <= 1'b0;
    end else begin
      inputReg <= inputNext;
      volumeReg <= volumeNext;
      fineReg <= fineNext;
      phaseReg <= phaseNext;
      commonReg <= commonNext;
      sourceReg <= sourceNext;
      rdataReg <= rdataNext;
      hitReg <= hitNext;
    end
  end

  // ==========================================================
  // gain path: staged through the sample-boundary holder
  ch4_gain_t pendingGain;
  ch4_gain_t appliedGain;
  assign pendingGain.mute = (volumeReg == VOL_MUTE);
  assign pendingGain.volume = volumeReg;
  assign pendingGain.fineGain = fineReg[FINE_LSB +: 4];
  assign pendingGain.phaseDelay = phaseReg[PHASE_LSB +: 6];

  sample_hold_reg gainHold (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sampleTick(sampleTick),
    .pending(pendingGain),
    .applied(appliedGain)
  );

  // ==========================================================
  // shared record controls and output source decode
  rec_ctrl_t ctrl;
  assign ctrl.cloneFromCh2 = inputReg[CLONE_BIT];
  assign ctrl.cmTrim = commonReg[CMTRIM_LSB +: 4];
  assign ctrl.quantCal = commonReg[QCAL_BIT];
  assign ctrl.invertData = commonReg[INVERT_BIT];

  wire [2:0] srcField = sourceReg[SRC_LSB +: 3];
  wire [2:0] routeField = sourceReg[ROUTE_LSB +: 3];
  wire splitMode = (srcField == SRC_SPLIT_PLAY_POS) || (srcField == SRC_SPLIT_PLAY_NEG);
  // one-hot check: a trim with more than one bit set is a software slip
  wire trimOneHot = (ctrl.cmTrim != 4'h0) && ((ctrl.cmTrim & (ctrl.cmTrim - 4'h1)) == 4'h0);
  out_route_t routeDecoded;

  out_source_decode srcDecode (
    .sourceCode(srcField),
    .route(routeDecoded)
  );

  // ==========================================================
  // registered outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch4CloneFromCh2 <= 1'b0;
      ch4Mute <= 1'b0;
      ch4VolumeCode <= RST_CH4_VOLUME;
      ch4VolumeHalfDb <= '0;
      ch4FineGain <= FINE_UNITY;
      ch4FineTenthDb <= '0;
      ch4PhaseDelay <= '0;
      inputCmTrim <= '0;
      cmTrimOneHot <= 1'b0;
      quantizerOffsetCal <= 1'b0;
      invertRecData <= 1'b0;
      out1SourceSelect <= RST_OUT1_SOURCE[SRC_LSB +: 3];
      out1Routing <= '0;
      out1RoutingIgnored <= 1'b0;
      out1Route <= '0;
    end else begin
      ch4CloneFromCh2 <= ctrl.cloneFromCh2;
      ch4Mute <= appliedGain.mute;
      ch4VolumeCode <= appliedGain.volume;
      ch4VolumeHalfDb <= appliedGain.mute ? 10'sd0 : vol_to_half_db(appliedGain.volume);
      ch4FineGain <= appliedGain.fineGain;
      ch4FineTenthDb <= $signed({1'b0, appliedGain.fineGain}) - $signed({1'b0, FINE_UNITY});
      ch4PhaseDelay <= appliedGain.phaseDelay;
      inputCmTrim <= ctrl.cmTrim;
      cmTrimOneHot <= trimOneHot;
      quantizerOffsetCal <= ctrl.quantCal;
      invertRecData <= ctrl.invertData;
      out1SourceSelect <= srcField;
      out1Routing <= routeField;
      out1RoutingIgnored <= splitMode;
      out1Route <= routeDecoded;
    end
  end

  assign regRdata = rdataReg;
  assign regHit = hitReg;

endmodule : rec_ch4_cfg

/* File: rec_cfg_pkg.sv */
package rec_cfg_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CH4_INPUT = 8'h5e;
  localparam logic [7:0] OFS_CH4_VOLUME = 8'h5f;
  localparam logic [7:0] OFS_CH4_FINE = 8'h60;
  localparam logic [7:0] OFS_CH4_PHASE = 8'h61;
  localparam logic [7:0] OFS_REC_COMMON = 8'h62;
  localparam logic [7:0] OFS_OUT1_SOURCE = 8'h64;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CH4_INPUT = 8'h00;
  localparam logic [7:0] RST_CH4_VOLUME = 8'ha1;
  localparam logic [7:0] RST_CH4_FINE = 8'h80;
  localparam logic [7:0] RST_CH4_PHASE = 8'h00;
  localparam logic [7:0] RST_REC_COMMON = 8'h00;
  localparam logic [7:0] RST_OUT1_SOURCE = 8'h20;

  // ==========================================================
  // writable bit masks; cleared bits are reserved and read back as reset
  localparam logic [7:0] MASK_CH4_INPUT = 8'h80;
  localparam logic [7:0] MASK_CH4_VOLUME = 8'hff;
  localparam logic [7:0] MASK_CH4_FINE = 8'hf0;
  localparam logic [7:0] MASK_CH4_PHASE = 8'hfc;
  localparam logic [7:0] MASK_REC_COMMON = 8'hfc;
  localparam logic [7:0] MASK_OUT1_SOURCE = 8'hff;

  // ==========================================================
  // field positions
  localparam int CLONE_BIT = 7;
  localparam int FINE_LSB = 4;
  localparam int PHASE_LSB = 2;
  localparam int CMTRIM_LSB = 4;
  localparam int QCAL_BIT = 3;
  localparam int INVERT_BIT = 2;
  localparam int SRC_LSB = 5;
  localparam int ROUTE_LSB = 2;

  // ==========================================================
  // code meanings
  localparam logic [7:0] VOL_MUTE = 8'h00;
  localparam logic [7:0] VOL_UNITY = 8'ha1;
  localparam logic [3:0] FINE_UNITY = 4'h8;

  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_PLAYBACK = 3'h1,
    SRC_BYPASS = 3'h2,
    SRC_MIX = 3'h3,
    SRC_SPLIT_PLAY_POS = 3'h4,
    SRC_SPLIT_PLAY_NEG = 3'h5
  } out_src_t;

  // decoded routing toward the output driver
  typedef struct packed {
    logic driverOn;
    logic playToPos;
    logic playToNeg;
    logic bypassToPos;
    logic bypassToNeg;
    logic mixed;
  } out_route_t;

  // channel-4 settings applied at a sample boundary
  typedef struct packed {
    logic mute;
    logic [7:0] volume;
    logic [3:0] fineGain;
    logic [5:0] phaseDelay;
  } ch4_gain_t;

  // shared record-path controls
  typedef struct packed {
    logic cloneFromCh2;
    logic [3:0] cmTrim;
    logic quantCal;
    logic invertData;
  } rec_ctrl_t;

endpackage : rec_cfg_pkg

/* File: out_source_decode.sv */
`timescale 1ns/1ps
module out_source_decode
  import rec_cfg_pkg::*;
(
  input wire logic [2:0] sourceCode,
  output out_route_t route
);
  // ==========================================================
  // source decode; reserved codes 6 and 7 fall back to driver off
  wire out_src_t src = out_src_t'(sourceCode);
  wire isLegal = (sourceCode <= 3'h5);
  wire usePlay = isLegal && (src == SRC_PLAYBACK || src == SRC_MIX);
  wire useByp = isLegal && (src == SRC_BYPASS || src == SRC_MIX);

  assign route.driverOn = isLegal && (src != SRC_OFF);
  assign route.mixed = isLegal && (src == SRC_MIX);
  assign route.playToPos = usePlay || (isLegal && src == SRC_SPLIT_PLAY_POS);
  assign route.playToNeg = usePlay || (isLegal && src == SRC_SPLIT_PLAY_NEG);
  assign route.bypassToPos = useByp || (isLegal && src == SRC_SPLIT_PLAY_NEG);
  assign route.bypassToNeg = useByp || (isLegal && src == SRC_SPLIT_PLAY_POS);

endmodule : out_source_decode

/* File: sample_hold_reg.sv */
`timescale 1ns/1ps
module sample_hold_reg
  import rec_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sampleTick,
  input ch4_gain_t pending,
  output ch4_gain_t applied
);
  // ==========================================================
  // holds the live gain set; changes only on a sample boundary so a
  // sample is never processed with half old, half new settings
  ch4_gain_t appliedReg;
  localparam ch4_gain_t RST_APPLIED = '{mute: 1'b0, volume: VOL_UNITY,
    fineGain: FINE_UNITY, phaseDelay: '0};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      appliedReg <= RST_APPLIED;
    end else if (sampleTick) begin
      appliedReg <= pending;
    end
  end

  assign applied = appliedReg;

endmodule : sample_hold_reg

/* File: rec_ch4_cfg_monitor.sv */
`timescale 1ns/1ps
module rec_ch4_cfg_monitor
  import rec_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic regHit,
  input wire logic sampleTick,
  input wire logic ch4CloneFromCh2,
  input wire logic ch4Mute,
  input wire logic [7:0] ch4VolumeCode,
  input wire logic signed [9:0] ch4VolumeHalfDb,
  input wire logic [3:0] ch4FineGain,
  input wire logic signed [4:0] ch4FineTenthDb,
  input wire logic [5:0] ch4PhaseDelay,
  input wire logic [3:0] inputCmTrim,
  input wire logic cmTrimOneHot,
  input wire logic [2:0] out1SourceSelect,
  input wire logic out1RoutingIgnored,
  input wire out_route_t out1Route
);
  // ==========================================================
  // helpers
  wire logic mappedAddr = regAddr inside {[8'h5e:8'h62], 8'h64};
  wire logic cloneWrite = regWrite && regAddr == OFS_CH4_INPUT;
  wire logic [17:0] gainSet = {ch4VolumeCode, ch4FineGain, ch4PhaseDelay};

  function automatic out_route_t routeOf(input logic [2:0] s);
    case (s)
      3'h1: return 6'h38;
      3'h2: return 6'h26;
      3'h3: return 6'h3f;
      3'h4: return 6'h32;
      3'h5: return 6'h2c;
      default: return 6'h00;
    endcase
  endfunction : routeOf

  // ==========================================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_mute_code: assert property (ch4Mute == (ch4VolumeCode == VOL_MUTE))
    else $error("mute flag disagrees with volume code");
  chk_half_db: assert property (ch4VolumeHalfDb == (ch4Mute ? 10'sh000 :
    $signed({2'b00, ch4VolumeCode}) - 10'sh0a1)) else $error("volume gain wrong");
  chk_fine_tenth: assert property (ch4FineTenthDb == $signed({1'b0, ch4FineGain}) - 5'sh08)
    else $error("fine gain offset wrong");
  chk_trim_onehot: assert property (cmTrimOneHot == $onehot(inputCmTrim))
    else $error("trim one-hot flag wrong");
  // the route flop is cleared in reset while the source flop holds its reset code,
  // so the first edge after release still shows the reset route
  chk_route_code: assert property ($past(rst_b) |-> out1Route == routeOf(out1SourceSelect))
    else $error("output route decode wrong");
  chk_routing_ignored: assert property (out1RoutingIgnored == (out1SourceSelect inside {3'h4, 3'h5}))
    else $error("routing ignore flag wrong");
  // gain must never move between sample boundaries
  chk_gain_tick: assert property ($changed(gainSet) |-> $past(sampleTick) || $past(sampleTick, 2))
    else $error("gain changed without sample tick");
  chk_clone_write: assert property ($changed(ch4CloneFromCh2) |-> $past(cloneWrite) || $past(cloneWrite, 2))
    else $error("clone changed without write");
  chk_hit_cause: assert property (regHit |-> $past(regRead || regWrite) && $past(mappedAddr))
    else $error("hit without mapped access");
  chk_hit_follow: assert property ((regRead || regWrite) && mappedAddr |=> regHit)
    else $error("mapped access without hit");

  cover property (regRead && mappedAddr);
  cover property (ch4Mute);
  cover property (out1RoutingIgnored);
endmodule : rec_ch4_cfg_monitor

bind rec_ch4_cfg rec_ch4_cfg_monitor u_mon (.core_clk, .rst_b, .regWrite, .regRead, .regAddr,
  .regHit, .sampleTick, .ch4CloneFromCh2, .ch4Mute, .ch4VolumeCode, .ch4VolumeHalfDb,
  .ch4FineGain, .ch4FineTenthDb, .ch4PhaseDelay, .inputCmTrim, .cmTrimOneHot,
  .out1SourceSelect, .out1RoutingIgnored, .out1Route);

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import rec_cfg_pkg::*;
;
  logic core_clk, rst_b, regWrite, regRead, sampleTick, regHit, ch4CloneFromCh2, ch4Mute;
  logic cmTrimOneHot, quantizerOffsetCal, invertRecData, out1RoutingIgnored;
  logic [7:0] regAddr, regWdata, regRdata, ch4VolumeCode;
  logic signed [9:0] ch4VolumeHalfDb;
  logic signed [4:0] ch4FineTenthDb;
  logic [3:0] ch4FineGain, inputCmTrim;
  logic [5:0] ch4PhaseDelay;
  logic [2:0] out1SourceSelect, out1Routing;
  out_route_t out1Route;
  int failures = 0;
  int testsRun = 0;
  logic [7:0] shadow [6];
  logic [7:0] addrs [6] = '{8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h64};
  logic [7:0] rsts [6] = '{8'h00, 8'ha1, 8'h80, 8'h00, 8'h00, 8'h20};
  logic [7:0] masks [6] = '{8'h80, 8'hff, 8'hf0, 8'hfc, 8'hfc, 8'hff};
  logic [7:0] edgeVals [3] = '{8'h01, 8'ha1, 8'hff};
  logic [5:0] routes [6] = '{6'h00, 6'h38, 6'h26, 6'h3f, 6'h32, 6'h2c};

  rec_ch4_cfg u_dut (.core_clk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .regHit, .sampleTick, .ch4CloneFromCh2, .ch4Mute, .ch4VolumeCode, .ch4VolumeHalfDb,
    .ch4FineGain, .ch4FineTenthDb, .ch4PhaseDelay, .inputCmTrim, .cmTrimOneHot,
    .quantizerOffsetCal, .invertRecData, .out1SourceSelect, .out1Routing,
    .out1RoutingIgnored, .out1Route);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] expRd(input int i, input logic [7:0] d);
    return (d & masks[i]) | (rsts[i] & ~masks[i]);
  endfunction : expRd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask : bus

  task automatic wr(input int i, input logic [7:0] d);
    bus(1'b1, addrs[i], d);
    shadow[i] = expRd(i, d);
  endtask : wr

  // outputs lag the tick by two edges, so three cycles is a safe settle
  task automatic tick();
    @(negedge core_clk);
    sampleTick = 1'b1;
    @(negedge core_clk);
    sampleTick = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : tick

  task automatic check_all();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, addrs[i], 8'h00);
      cmp({regHit, regRdata}, {1'b1, shadow[i]});
    end
    cmp({1'b0, ch4CloneFromCh2, ch4VolumeCode, ch4FineGain, ch4PhaseDelay, inputCmTrim,
      quantizerOffsetCal, invertRecData, out1SourceSelect, out1Routing}, {1'b0, shadow[0][7],
      shadow[1], shadow[2][7:4], shadow[3][7:2], shadow[4][7:2], shadow[5][7:2]});
    cmp({ch4Mute, cmTrimOneHot}, {shadow[1] == 8'h00, $onehot(shadow[4][7:4])});
  endtask : check_all

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    int i;
    logic [7:0] d;
    {rst_b, regWrite, regRead, sampleTick, regAddr, regWdata} = '0;
    void'($urandom(32'hb7cf_a8a4));
    // count rising edges: the clock's first assignment can look like a falling edge
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    shadow = rsts;
    check_all();
    for (int k = 0; k < 6; k++) wr(k, 8'hb3);
    tick();
    check_all();
    for (int n = 0; n < 60; n++) begin
      i = $urandom % 6;
      d = expRd(i, 8'($urandom));
      if (i == 5 && d[7:6] == 2'b11) d[7] = 1'b0;
      wr(i, d);
      if (n % 4 == 3) begin
        tick();
        check_all();
      end
    end
    wr(1, 8'h40);
    tick();
    wr(1, 8'h00);
    repeat (4) @(negedge core_clk);
    cmp(ch4VolumeCode, 8'h40);
    tick();
    cmp({ch4Mute, ch4VolumeHalfDb}, {1'b1, 10'h000});
    for (int k = 0; k < 3; k++) begin
      wr(1, edgeVals[k]);
      wr(2, {edgeVals[k][7:4], 4'h0});
      wr(3, {edgeVals[k][7:2], 2'b00});
      tick();
      cmp({ch4VolumeHalfDb, ch4FineTenthDb, ch4PhaseDelay}, {10'(edgeVals[k]) - 10'h0a1,
        5'(edgeVals[k][7:4]) - 5'h08, edgeVals[k][7:2]});
    end
    for (int k = 0; k < 6; k++) begin
      wr(5, {3'(k), 5'h0c});
      repeat (3) @(negedge core_clk);
      cmp({out1Route, out1RoutingIgnored}, {routes[k], k > 3});
    end
    bus(1'b1, 8'h63, 8'h5a);
    bus(1'b0, 8'h63, 8'h00);
    cmp({regHit, regRdata}, 9'h000);
    check_all();
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    shadow = rsts;
    check_all();
    close_out();
  end
endmodule : tb_top
